//--- hw/adcil_limit_cmp.sv
/*
  One watchdog limit comparison: signed sample against signed limit,
  direction bit picks above or below. Registered hit pulse.
  Assumes compare strobes come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adcil_limit_cmp
  import adcil_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cmp_valid,
  input wire logic signed [adcil_pkg::SAMPLE_W-1:0] sample,
  input wire logic signed [adcil_pkg::SAMPLE_W-1:0] limit,
  input wire logic dir_above,
  output logic hit
);
  // ------------------------------------------------------------
  // compare
  // ------------------------------------------------------------
  logic crossed;

  always_comb begin
    crossed = dir_above ? (sample > limit) : (sample < limit); // [RQ3]
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hit <= 1'b0;
    end else begin
      hit <= cmp_valid & crossed; // [RQ3]
    end
  end

  wd_hit_a: assert property (@(posedge sys_clk) disable iff (reset) // [RQ3]
    (cmp_valid && (dir_above ? sample > limit : sample < limit)) |=> hit)
    else $error("limit crossing not flagged");
endmodule : adcil_limit_cmp
`default_nettype wire

//--- hw/adcil_pkg.sv
/*
  Constants for the converter interrupt logic: register word indexes,
  field positions, reset values and timing.
  Assumes a single 100 MHz clock.
*/
package adcil_pkg;
  // ------------------------------------------------------------
  // register word indexes (address bits 4..1)
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_INT_MASK = 4'h9;
  localparam logic [3:0] IDX_INT_FLAGS = 4'ha;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  // ------------------------------------------------------------
  // fields
  // ------------------------------------------------------------
  localparam int NUM_SRC = 8;
  localparam int TRIG_LSB = 8;
  localparam int TRIG_W = 3;
  localparam int THR_LSB = 11;
  localparam int THR_W = 5;
  localparam int IP_LSB = 8;
  localparam int CNT_LSB = 11;
  localparam int FIFO_CNT_W = 6;
  localparam int SAMPLE_W = 9;
  // ------------------------------------------------------------
  // source bit positions
  // ------------------------------------------------------------
  localparam int SRC_WATCHDOG = 0;
  localparam int SRC_IP_MATCH = 1;
  localparam int SRC_FIFO_LVL = 2;
  localparam int SRC_CAL_SHORT = 3;
  localparam int SRC_CAL_FULL = 4;
  localparam int SRC_PAUSE = 5;
  localparam int SRC_LOW_SUPPLY = 6;
  localparam int SRC_STBY_EXIT = 7;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [2:0] TRIG_ZERO = 3'h0;
  localparam logic [4:0] THR_NONE = 5'h00;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STBY_SETTLE_MS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int STBY_SETTLE_CYCLES = (STBY_SETTLE_MS * NS_PER_MS) / CLK_PERIOD_NS;
endpackage : adcil_pkg

//--- hw/adcil_top.sv
/*
  Interrupt collection for the data acquisition converter: eight
  sticky flags, per-source mask, active-low interrupt pin, and the
  mask/trigger and flags/progress registers on the parallel bus.
  Assumes sequencer, FIFO, calibration and config logic on sys_clk;
  supply monitor and bus width strap are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// (RQ1) eight equal-priority sources; any unmasked one drives the interrupt pin
// (RQ2) host reads flags register once after every mask register write
// (RQ3) watchdog flag when either limit comparison detects a crossing
// (RQ4) instruction-match flag when fetched pointer equals trigger, before execution
// (RQ5) fill-level flag when stored count equals nonzero threshold
// (RQ6) short calibration done sets flag 3
// (RQ7) full calibration done sets flag 4
// (RQ8) fetch of instruction with pause bit sets flag 5
// (RQ9) low supply indication sets flag 6 whenever present
// (RQ10) flag 7 after settling delay following standby exit
// (RQ11) mask bits 0..7 gate flags onto the interrupt pin
// (RQ12) flags set regardless of mask
// (RQ13) trigger zero skips first fetch of instruction 0 after reset
// (RQ14) interrupts never stop the sequencer
// (RQ15) flags clear on flags register read and on reset
// (RQ16) flags register shows pointer in bits 8..10, count in 11..15
// (RQ17) flag bit positions follow source numbering
// (RQ18) reset control clears all flags and rearms first-fetch skip
// (RQ19) interrupt pin low when flags AND mask is nonzero
module adcil_top
  import adcil_pkg::*;
#(
  parameter int SETTLE_CYCLES = adcil_pkg::STBY_SETTLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [adcil_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [adcil_pkg::DATA_W-1:0] reg_wdata,
  output logic [adcil_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic bus_width_sel,
  input wire logic reset_ctl,
  input wire logic standby_ctl,
  input wire logic seq_running,
  input wire logic [adcil_pkg::TRIG_W-1:0] seq_ip,
  input wire logic fetch_pulse,
  input wire logic [adcil_pkg::TRIG_W-1:0] fetch_ip,
  input wire logic fetch_pause,
  input wire logic [adcil_pkg::FIFO_CNT_W-1:0] fifo_count,
  input wire logic cal_short_done,
  input wire logic cal_full_done,
  input wire logic wd_cmp_valid,
  input wire logic signed [adcil_pkg::SAMPLE_W-1:0] wd_sample,
  input wire logic signed [adcil_pkg::SAMPLE_W-1:0] wd_limit,
  input wire logic wd_dir_above,
  input wire logic supply_low,
  output logic int_n
);
  import adcil_pkg::*;

  localparam int SET_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [SET_W-1:0] SETTLE_LAST = SET_W'(SETTLE_CYCLES - 1);
  localparam logic [SET_W-1:0] SETTLE_ZERO = '0;
  localparam logic [SET_W-1:0] SETTLE_ONE = SET_W'(1);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [DATA_W-1:0] lane_pick(
    input logic [DATA_W-1:0] word, input logic narrow, input logic hi);
    logic [DATA_W-1:0] res;
    res = word;
    if (narrow) begin
      res = {{BYTE_W{1'b0}}, hi ? word[DATA_W-1:BYTE_W] : word[BYTE_W-1:0]};
    end
    return res;
  endfunction : lane_pick

  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] wr,
    input logic narrow, input logic hi);
    logic [DATA_W-1:0] res;
    res = wr;
    if (narrow) begin
      res = hi ? {wr[BYTE_W-1:0], old[BYTE_W-1:0]}
               : {old[DATA_W-1:BYTE_W], wr[BYTE_W-1:0]};
    end
    return res;
  endfunction : lane_merge

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic bw_meta_r;
  logic bw_r;
  logic sup_meta_r;
  logic sup_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bw_meta_r <= 1'b0;
      bw_r <= 1'b0;
      sup_meta_r <= 1'b0;
      sup_r <= 1'b0;
    end else begin
      bw_meta_r <= bus_width_sel;
      bw_r <= bw_meta_r;
      sup_meta_r <= supply_low;
      sup_r <= sup_meta_r;
    end
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic [3:0] idx;
  logic hi_lane;
  logic mask_wr;
  logic flags_rd;
  logic flags_clr;
  always_comb begin
    idx = reg_addr[ADDR_W-1:1];
    hi_lane = reg_addr[0];
    mask_wr = reg_wr_en && (idx == IDX_INT_MASK);
    flags_rd = reg_rd_en && (idx == IDX_INT_FLAGS);
    flags_clr = flags_rd && (!bw_r || hi_lane); // [RQ15]
  end

  // ------------------------------------------------------------
  // mask and trigger register
  // ------------------------------------------------------------
  logic [DATA_W-1:0] mask_r;
  logic [TRIG_W-1:0] trig;
  logic [THR_W-1:0] thr;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mask_r <= MASK_RESET;
    end else if (mask_wr) begin
      mask_r <= lane_merge(mask_r, reg_wdata, bw_r, hi_lane); // [RQ11]
    end
  end

  always_comb begin
    trig = mask_r[TRIG_LSB +: TRIG_W];
    thr = mask_r[THR_LSB +: THR_W];
  end

  // ------------------------------------------------------------
  // watchdog comparison
  // ------------------------------------------------------------
  logic wd_hit;
  adcil_limit_cmp u_cmp (
    .sys_clk(sys_clk),
    .reset(reset),
    .cmp_valid(wd_cmp_valid),
    .sample(wd_sample),
    .limit(wd_limit),
    .dir_above(wd_dir_above),
    .hit(wd_hit)
  );

  // ------------------------------------------------------------
  // instruction match, first-fetch skip
  // ------------------------------------------------------------
  logic first_zero_r;
  logic ip_hit;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      first_zero_r <= 1'b1;
    end else if (reset_ctl) begin
      first_zero_r <= 1'b1; // [RQ18]
    end else if (fetch_pulse && fetch_ip == TRIG_ZERO) begin
      first_zero_r <= 1'b0; // [RQ13]
    end
  end

  always_comb begin
    ip_hit = fetch_pulse && (fetch_ip == trig) // [RQ4]
             && !(trig == TRIG_ZERO && first_zero_r); // [RQ13]
  end

  // ------------------------------------------------------------
  // fill level
  // ------------------------------------------------------------
  logic lvl_eq;
  logic lvl_eq_r;
  always_comb begin
    lvl_eq = (thr != THR_NONE) && (fifo_count == {1'b0, thr}); // [RQ5]
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lvl_eq_r <= 1'b0;
    end else begin
      lvl_eq_r <= lvl_eq;
    end
  end

  // ------------------------------------------------------------
  // standby exit settling
  // ------------------------------------------------------------
  logic stby_prev_r;
  logic settle_busy_r;
  logic [SET_W-1:0] settle_cnt_r;
  logic settle_done;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stby_prev_r <= 1'b0;
    end else begin
      stby_prev_r <= standby_ctl;
    end
  end

  always_comb begin
    settle_done = settle_busy_r && (settle_cnt_r == SETTLE_LAST);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      settle_busy_r <= 1'b0;
      settle_cnt_r <= SETTLE_ZERO;
    end else if (standby_ctl) begin
      settle_busy_r <= 1'b0;
      settle_cnt_r <= SETTLE_ZERO;
    end else if (stby_prev_r) begin
      settle_busy_r <= 1'b1; // [RQ10]
      settle_cnt_r <= SETTLE_ZERO;
    end else if (settle_done) begin
      settle_busy_r <= 1'b0;
    end else if (settle_busy_r) begin
      settle_cnt_r <= settle_cnt_r + SETTLE_ONE;
    end
  end

  // ------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------
  logic [NUM_SRC-1:0] set_vec;
  logic [NUM_SRC-1:0] flags_r;
  logic [NUM_SRC-1:0] flags_nxt;
  always_comb begin
    set_vec = '0;
    set_vec[SRC_WATCHDOG] = wd_hit; // [RQ3] [RQ17]
    set_vec[SRC_IP_MATCH] = ip_hit; // [RQ4]
    set_vec[SRC_FIFO_LVL] = lvl_eq && !lvl_eq_r; // [RQ5]
    set_vec[SRC_CAL_SHORT] = cal_short_done; // [RQ6]
    set_vec[SRC_CAL_FULL] = cal_full_done; // [RQ7]
    set_vec[SRC_PAUSE] = fetch_pulse && fetch_pause; // [RQ8]
    set_vec[SRC_LOW_SUPPLY] = sup_r; // [RQ9]
    set_vec[SRC_STBY_EXIT] = settle_done; // [RQ10]
    if (reset_ctl) begin
      flags_nxt = FLAGS_RESET; // [RQ18]
    end else begin
      // set wins over read clear; mask not consulted
      flags_nxt = (flags_r & ~{NUM_SRC{flags_clr}}) | set_vec; // [RQ12] [RQ15]
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flags_r <= FLAGS_RESET; // [RQ15]
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ------------------------------------------------------------
  // interrupt pin
  // ------------------------------------------------------------
  // no path back to the sequencer: raising never halts it [RQ14]
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~|(flags_r & mask_r[NUM_SRC-1:0]); // [RQ1] [RQ11] [RQ19]
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [DATA_W-1:0] flags_word;
  logic [DATA_W-1:0] rd_word;
  always_comb begin
    flags_word = {fifo_count[THR_W-1:0], seq_ip, flags_r}; // [RQ16] [RQ17]
    case (idx)
      IDX_INT_MASK: rd_word = mask_r;
      IDX_INT_FLAGS: rd_word = flags_word;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= lane_pick(rd_word, bw_r, hi_lane);
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence first_zero_fetch;
    fetch_pulse && fetch_ip == TRIG_ZERO && trig == TRIG_ZERO
      && first_zero_r && !flags_r[SRC_IP_MATCH] && !flags_clr && !reset_ctl;
  endsequence
  sequence quiet_read;
    flags_clr && !reset_ctl && set_vec == '0;
  endsequence

  pin_level_a: assert property ( // [RQ19]
    ##1 (int_n == !(|($past(flags_r) & $past(mask_r[NUM_SRC-1:0])))))
    else $error("interrupt pin disagrees with flags and mask");
  unmasked_pin_a: assert property ( // [RQ1]
    (!reset_ctl && cal_short_done && mask_r[SRC_CAL_SHORT] && !mask_wr)
      |=> ##1 !int_n)
    else $error("unmasked source did not pull pin low");
  ip_match_a: assert property ( // [RQ4]
    (ip_hit && !reset_ctl) |=> flags_r[SRC_IP_MATCH])
    else $error("instruction match not flagged");
  first_skip_a: assert property ( // [RQ13]
    first_zero_fetch |=> !flags_r[SRC_IP_MATCH] && !first_zero_r)
    else $error("first fetch of instruction zero flagged");
  fill_level_a: assert property ( // [RQ5]
    (!reset_ctl && thr != THR_NONE && fifo_count == {1'b0, thr} && !lvl_eq_r)
      |=> flags_r[SRC_FIFO_LVL])
    else $error("fill level not flagged");
  cal_flags_a: assert property ( // [RQ6] [RQ7]
    (!reset_ctl && (cal_short_done || cal_full_done))
      |=> (flags_r[SRC_CAL_SHORT] || !$past(cal_short_done)) && (flags_r[SRC_CAL_FULL] || !$past(cal_full_done)))
    else $error("calibration done not flagged");
  pause_flag_a: assert property ( // [RQ8]
    (!reset_ctl && fetch_pulse && fetch_pause) |=> flags_r[SRC_PAUSE])
    else $error("pause fetch not flagged");
  low_supply_a: assert property ( // [RQ9]
    (!reset_ctl && sup_r) |=> flags_r[SRC_LOW_SUPPLY])
    else $error("low supply not flagged");
  stby_exit_a: assert property ( // [RQ10]
    (!reset_ctl && settle_done) |=> flags_r[SRC_STBY_EXIT] && !settle_busy_r)
    else $error("standby exit not flagged");
  read_clear_a: assert property ( // [RQ15]
    quiet_read |=> flags_r == FLAGS_RESET)
    else $error("flags not cleared by read");
  set_wins_a: assert property ( // [RQ12]
    (flags_clr && !reset_ctl && wd_hit) |=> flags_r[SRC_WATCHDOG])
    else $error("set lost against read clear");
  reset_ctl_a: assert property ( // [RQ18]
    reset_ctl |=> flags_r == FLAGS_RESET && first_zero_r)
    else $error("reset control left flags set");
  progress_view_a: assert property ( // [RQ16]
    (reg_rd_en && idx == IDX_INT_FLAGS && !bw_r)
      |=> reg_rdata[DATA_W-1:IP_LSB] == {$past(fifo_count[THR_W-1:0]), $past(seq_ip)})
    else $error("progress fields wrong");

endmodule : adcil_top
`default_nettype wire

//--- verification/adcil_host_model.sv
/*
  Host processor model on the parallel register bus: word or byte-lane
  writes and reads, mask write followed by the flags read.
  Assumes strobes are taken at the rising edge of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module adcil_host_model
  import adcil_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [adcil_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rd_valid,
  output logic [adcil_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [adcil_pkg::DATA_W-1:0] reg_wdata
);
  import adcil_pkg::*;
  initial begin
    reg_addr = 5'h00;
    reg_wr_en = 1'h0;
    reg_rd_en = 1'h0;
    reg_wdata = 16'h0000;
  end
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  task automatic wr_at(input logic [4:0] a, input logic [15:0] dat);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = dat;
    reg_wr_en = 1'h1;
    @(negedge sys_clk);
    reg_wr_en = 1'h0;
    reg_wdata = ~dat;
  endtask : wr_at
  // answer stands for the cycle after the taking edge: capture it there
  task automatic rd_at(input logic [4:0] a, output logic [15:0] dat, output logic vld);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'h1;
    @(negedge sys_clk);
    dat = reg_rdata;
    vld = reg_rd_valid;
    reg_rd_en = 1'h0;
  endtask : rd_at
  task automatic wr(input logic [3:0] idx, input logic [15:0] dat);
    wr_at({idx, 1'h0}, dat);
  endtask : wr
  task automatic rd(input logic [3:0] idx, output logic [15:0] dat, output logic vld);
    rd_at({idx, 1'h0}, dat, vld);
  endtask : rd
  task automatic wr_mask(input logic [15:0] dat);
    logic [15:0] junk;
    logic jv;
    wr(IDX_INT_MASK, dat);
    rd(IDX_INT_FLAGS, junk, jv);
  endtask : wr_mask
endmodule : adcil_host_model
`default_nettype wire

//--- verification/tb.sv
/*
  Self-checking bench for the converter interrupt logic: reset case,
  table of per-source cases, then trigger, threshold, watchdog, reset
  control, access, device reset and byte-lane cases.
  Assumes adcil_top with a short standby settle count.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adcil_pkg::*;
  typedef struct {int src; logic [15:0] mask; logic exp_n;} adcil_row_type;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic [4:0] reg_addr;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, v, int_n;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic reset_ctl = 1'h0, standby_ctl = 1'h0, fetch_pulse = 1'h0, fetch_pause = 1'h0;
  logic [2:0] seq_ip = 3'h2, fetch_ip = 3'h0;
  logic [5:0] fifo_count = 6'h00;
  logic cal_short_done = 1'h0, cal_full_done = 1'h0, wd_cmp_valid = 1'h0, wd_dir_above = 1'h0;
  logic supply_low = 1'h0, bus_width_sel = 1'h0, seq_running = 1'h1;
  logic signed [8:0] wd_sample = 9'sh000, wd_limit = 9'sh000;
  int fails = 0, check_count = 0;
  adcil_row_type rows [10] = '{'{0, 16'h2b01, 1'h0}, '{1, 16'h2b02, 1'h0}, '{2, 16'h2b04, 1'h0},
    '{3, 16'h2b08, 1'h0}, '{4, 16'h2b10, 1'h0}, '{5, 16'h2b20, 1'h0}, '{6, 16'h2b40, 1'h0},
    '{7, 16'h2b80, 1'h0}, '{3, 16'h2bf7, 1'h1}, '{6, 16'h2bbf, 1'h1}};

  always #5 sys_clk = ~sys_clk;

  adcil_top #(.SETTLE_CYCLES(8)) u_adcil_top (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .bus_width_sel(bus_width_sel), .reset_ctl(reset_ctl), .standby_ctl(standby_ctl),
    .seq_running(seq_running), .seq_ip(seq_ip), .fetch_pulse(fetch_pulse), .fetch_ip(fetch_ip),
    .fetch_pause(fetch_pause), .fifo_count(fifo_count), .cal_short_done(cal_short_done),
    .cal_full_done(cal_full_done), .wd_cmp_valid(wd_cmp_valid), .wd_sample(wd_sample),
    .wd_limit(wd_limit), .wd_dir_above(wd_dir_above), .supply_low(supply_low), .int_n(int_n));
  adcil_host_model u_adcil_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic flags(input logic [7:0] e);
    u_adcil_host_model.rd(IDX_INT_FLAGS, d, v);
    chk("read valid", 16'h0001, {15'h0000, v});
    chk("flags", {8'h00, e}, {8'h00, d[7:0]});
  endtask : flags
  task automatic fetch(input logic [2:0] ip, input logic p);
    tick(1);
    fetch_ip = ip;
    fetch_pause = p;
    fetch_pulse = 1'h1;
    tick(1);
    fetch_pulse = 1'h0;
  endtask : fetch
  task automatic wd(input logic signed [8:0] s, input logic signed [8:0] l, input logic up);
    tick(1);
    wd_sample = s;
    wd_limit = l;
    wd_dir_above = up;
    wd_cmp_valid = 1'h1;
    tick(1);
    wd_cmp_valid = 1'h0;
  endtask : wd
  task automatic rctl();
    tick(1);
    reset_ctl = 1'h1;
    tick(1);
    reset_ctl = 1'h0;
  endtask : rctl
  task automatic fire(input int s);
    tick(1);
    case (s)
      0: wd(9'sh005, 9'sh003, 1'h1);
      1: fetch(3'h3, 1'h0);
      2: begin
        fifo_count = 6'h04;
        tick(1);
        fifo_count = 6'h05;
      end
      3: cal_short_done = 1'h1;
      4: cal_full_done = 1'h1;
      5: fetch(3'h6, 1'h1);
      6: supply_low = 1'h1;
      default: begin
        standby_ctl = 1'h1;
        tick(2);
        standby_ctl = 1'h0;
        tick(10);
      end
    endcase
    tick(1);
    cal_short_done = 1'h0;
    cal_full_done = 1'h0;
    supply_low = 1'h0;
  endtask : fire

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    @(negedge sys_clk);
    chk("int_n in reset", 16'h0001, {15'h0000, int_n});
    chk("rdata in reset", 16'h0000, reg_rdata);
    repeat (2) @(negedge sys_clk);
    reset = 1'h0;
    u_adcil_host_model.rd(IDX_INT_MASK, d, v);
    chk("mask reset", MASK_RESET, d);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      seq_ip = i[2:0];
      u_adcil_host_model.wr_mask(rows[i].mask);
      fire(rows[i].src);
      tick(6);
      chk("int_n", {15'h0000, rows[i].exp_n}, {15'h0000, int_n});
      u_adcil_host_model.rd(IDX_INT_FLAGS, d, v);
      chk("status", {fifo_count[4:0], seq_ip, 8'h01 << rows[i].src}, d);
      tick(2);
      chk("int_n after read", 16'h0001, {15'h0000, int_n});
      u_adcil_host_model.rd(IDX_INT_MASK, d, v);
      chk("mask", rows[i].mask, d);
      $display("row %0d done", i);
    end
    rctl();
    u_adcil_host_model.wr_mask(16'h0002);
    fetch(3'h0, 1'h0);
    tick(3);
    flags(8'h00);
    fetch(3'h0, 1'h0);
    tick(3);
    flags(8'h02);
    $display("first fetch test done");
    u_adcil_host_model.wr_mask(16'h0004);
    tick(1);
    fifo_count = 6'h01;
    tick(1);
    fifo_count = 6'h00;
    tick(3);
    flags(8'h00);
    u_adcil_host_model.wr_mask(16'hf804);
    tick(1);
    fifo_count = 6'h1e;
    tick(1);
    fifo_count = 6'h1f;
    tick(3);
    flags(8'h04);
    $display("threshold test done");
    u_adcil_host_model.wr_mask(16'h0001);
    wd(-9'sd4, 9'sh002, 1'h0);
    tick(3);
    flags(8'h01);
    wd(9'sh004, 9'sh002, 1'h0);
    tick(3);
    flags(8'h00);
    fork
      wd(9'sh010, 9'sh002, 1'h1);
      begin
        tick(1);
        u_adcil_host_model.rd(IDX_INT_FLAGS, d, v);
      end
    join
    flags(8'h01);
    $display("watchdog test done");
    u_adcil_host_model.wr_mask(16'h0008);
    fire(3);
    tick(3);
    chk("int_n set", 16'h0000, {15'h0000, int_n});
    rctl();
    tick(2);
    chk("int_n after reset control", 16'h0001, {15'h0000, int_n});
    flags(8'h00);
    $display("reset control test done");
    u_adcil_host_model.wr(IDX_INT_FLAGS, 16'h00ff);
    flags(8'h00);
    u_adcil_host_model.wr(4'h3, 16'hffff);
    u_adcil_host_model.rd(4'h3, d, v);
    chk("unmapped", 16'h0000, d);
    $display("access test done");
    u_adcil_host_model.wr_mask(16'h0010);
    fire(4);
    tick(2);
    chk("int_n before reset", 16'h0000, {15'h0000, int_n});
    reset = 1'h1;
    tick(1);
    chk("int_n in second reset", 16'h0001, {15'h0000, int_n});
    reset = 1'h0;
    flags(8'h00);
    u_adcil_host_model.rd(IDX_INT_MASK, d, v);
    chk("mask after reset", MASK_RESET, d);
    $display("device reset test done");
    bus_width_sel = 1'h1;
    seq_running = 1'h0;
    tick(3);
    u_adcil_host_model.wr_at({IDX_INT_MASK, 1'h0}, 16'h0008);
    u_adcil_host_model.wr_at({IDX_INT_MASK, 1'h1}, 16'h00a5);
    u_adcil_host_model.rd_at({IDX_INT_FLAGS, 1'h1}, d, v);
    u_adcil_host_model.rd_at({IDX_INT_MASK, 1'h1}, d, v);
    chk("mask high byte", 16'h00a5, d);
    fire(3);
    u_adcil_host_model.rd_at({IDX_INT_FLAGS, 1'h0}, d, v);
    chk("flags low byte", 16'h0008, d);
    tick(2);
    chk("int_n after low byte read", 16'h0000, {15'h0000, int_n});
    u_adcil_host_model.rd_at({IDX_INT_FLAGS, 1'h1}, d, v);
    chk("progress high byte", {8'h00, fifo_count[4:0], seq_ip}, d);
    tick(2);
    chk("int_n after high byte read", 16'h0001, {15'h0000, int_n});
    bus_width_sel = 1'h0;
    seq_running = 1'h1;
    $display("byte lane test done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("watchdog expired");
    close_out();
  end
endmodule : tb
`default_nettype wire
